// *** fsag_pkg.sv ***
// Contract
// - Firmware program-space stores write or erase flash, constant reads read flash, external-data reads always go to on-chip RAM.
// - Software may not modify flash unless the store write enable is 1.
// - A software erase proceeds only when both store write enable and store erase enable are 1.
// - The ones complement of the lock byte at the top of user flash is the count of locked 512-byte pages from page 0.
// - The lock-byte page is unlocked while the lock byte is all ones and locked once any bit is zero.
// - Unlocked pages other than the lock-byte page are open to the debug port and to all firmware.
// - Locked pages are refused to the debug port, fault-reset firmware on unlocked pages, and are open to locked firmware.
// - With any page locked, lock-byte page reads and writes are refused to debug and fault unlocked firmware.
// - Firmware erase of the lock-byte page always faults; debug may erase it only while nothing is locked.
// - A debug whole-device erase clears every page, including the lock-byte page, and unlocks everything.
// - A written lock byte may not change; firmware attempts fault, debug attempts are refused, until device erase.
// - Any access to the reserved area is refused to debug and faults firmware.
// - Prohibited debug operations are ignored silently and never reset the device.
// - Every flash-error reset leaves the flash fault flag at 1 after the reset.
// - A lock byte written by user code takes effect only after the next device reset.
package fsag_pkg;
	localparam int ADDR_W = 17;
	localparam int PAGE_W = 8;
	localparam int PAGE_LSB = 9;
	// User space ends just below the reserved block at the top of the array
	localparam logic [ADDR_W-1:0] LOCK_BYTE_ADDR = 17'h1fbff;
	localparam logic [ADDR_W-1:0] RESERVED_BASE = 17'h1fc00;
	localparam logic [PAGE_W-1:0] LOCK_PAGE = LOCK_BYTE_ADDR[ADDR_W-1:PAGE_LSB];
	localparam logic [7:0] LOCK_OPEN = 8'hff;
	localparam logic [7:0] LOCK_RESET_VAL = 8'hff;

	typedef enum logic [2:0] {
		FSAG_OP_READ,
		FSAG_OP_WRITE,
		FSAG_OP_ERASE,
		FSAG_OP_DEV_ERASE,
		FSAG_OP_XDATA_READ
	} fsag_op_type;

	typedef enum logic {
		FSAG_SRC_FW,
		FSAG_SRC_DEBUG
	} fsag_src_type;

	typedef enum logic [1:0] {
		FSAG_TGT_NONE,
		FSAG_TGT_FLASH,
		FSAG_TGT_ONCHIP_EXTERNAL_DATA_RAM
	} fsag_tgt_type;
endpackage : fsag_pkg

// *** fsag_lock_capture.sv ***
`timescale 1ns/100ps
module fsag_lock_capture
	import fsag_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic [7:0]       flash_lock_byte,
	input  wire logic             device_erase,
	output logic      [PAGE_W-1:0] locked_pages,
	output logic                  any_locked
);
	logic [7:0] lock_r;
	logic       captured_r;

	// **********************************
	// Lock capture
	// **********************************
	// capture at release
	always_ff @(posedge core_clk) begin
		if (rst) begin
			lock_r     <= LOCK_RESET_VAL;
			captured_r <= 1'b0;
		end else if (device_erase) begin
			lock_r     <= LOCK_OPEN;
			captured_r <= 1'b1;
		end else if (!captured_r) begin
			lock_r     <= flash_lock_byte;
			captured_r <= 1'b1;
		end
	end

	assign locked_pages = ~lock_r;
	assign any_locked = (lock_r != LOCK_OPEN);
endmodule : fsag_lock_capture

// *** fsag_guard.sv ***
`timescale 1ns/100ps
module fsag_guard
	import fsag_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              power_on_rst,
	input  wire logic              store_write_enable,
	input  wire logic              store_erase_enable,
	input  wire logic [7:0]        flash_lock_byte,
	input  wire logic [ADDR_W-1:0] exec_addr,
	input  wire logic              req_valid,
	input  wire fsag_src_type      req_src,
	input  wire fsag_op_type       req_op,
	input  wire logic [ADDR_W-1:0] req_addr,
	output logic                   resp_valid,
	output fsag_tgt_type           resp_target,
	output fsag_op_type            resp_op,
	output logic [ADDR_W-1:0]      resp_addr,
	output logic                   resp_refused,
	output logic                   flash_fault_reset,
	output logic                   flash_fault_reset_flag
);
	logic [PAGE_W-1:0] locked_pages;
	logic              any_locked;
	logic              dev_erase_go;
	logic [PAGE_W-1:0] tgt_page;
	logic [PAGE_W-1:0] exec_page;
	logic              fw_locked;
	logic              tgt_locked;
	logic              tgt_lock_page;
	logic              tgt_reserved;
	logic              is_debug;
	logic              bad;
	fsag_op_type       eff_op;
	fsag_tgt_type      tgt_nxt;
	logic              refuse_nxt;
	logic              fault_nxt;
	logic              resp_valid_r;
	fsag_tgt_type      resp_target_r;
	fsag_op_type       resp_op_r;
	logic [ADDR_W-1:0] resp_addr_r;
	logic              resp_refused_r;
	logic              fault_req_r;
	logic              flag_r;
	logic              rst_prev_r;
	logic              take_req;

	// **********************************
	// Lock state
	// **********************************
	fsag_lock_capture fsag_lock_capture_inst (
		.core_clk        (core_clk),
		.rst             (rst),
		.flash_lock_byte (flash_lock_byte),
		.device_erase    (dev_erase_go),
		.locked_pages    (locked_pages),
		.any_locked      (any_locked)
	);

	// **********************************
	// Address classes
	// **********************************
	assign tgt_page  = req_addr[ADDR_W-1:PAGE_LSB];
	assign exec_page = exec_addr[ADDR_W-1:PAGE_LSB];
	assign is_debug  = (req_src == FSAG_SRC_DEBUG);

	assign tgt_locked    = (tgt_page < locked_pages);
	assign tgt_lock_page = (tgt_page == LOCK_PAGE);
	assign tgt_reserved  = (req_addr >= RESERVED_BASE);

	// Code running from the lock page counts as locked code once anything is locked
	assign fw_locked = (exec_page < locked_pages) || (any_locked && exec_page == LOCK_PAGE);

	// **********************************
	// Operation steering
	// **********************************
	always_comb begin
		eff_op  = req_op;
		tgt_nxt = FSAG_TGT_FLASH;
		if (!is_debug) begin
			unique case (req_op)
				FSAG_OP_XDATA_READ: tgt_nxt = FSAG_TGT_ONCHIP_EXTERNAL_DATA_RAM;
				FSAG_OP_WRITE: begin
					// no store enable means plain RAM write
					if (!store_write_enable) begin
						tgt_nxt = FSAG_TGT_ONCHIP_EXTERNAL_DATA_RAM;
					end else if (store_erase_enable) begin
						eff_op = FSAG_OP_ERASE;
					end
				end
				FSAG_OP_READ: tgt_nxt = FSAG_TGT_FLASH;
				// Firmware has no direct erase or device erase path
				default: tgt_nxt = FSAG_TGT_NONE;
			endcase
		end else if (req_op == FSAG_OP_XDATA_READ) begin
			// Debug has no external-data path, and the store enables guard software only
			tgt_nxt = FSAG_TGT_NONE;
		end
	end

	// **********************************
	// Security decision
	// **********************************
	always_comb begin
		bad = 1'b0;
		if (tgt_nxt == FSAG_TGT_FLASH && eff_op != FSAG_OP_DEV_ERASE) begin
			if (tgt_reserved) begin
				bad = 1'b1;
			end else if (tgt_lock_page && eff_op == FSAG_OP_ERASE) begin
				bad = !is_debug || any_locked;
			end else if (eff_op == FSAG_OP_WRITE && req_addr == LOCK_BYTE_ADDR
				&& flash_lock_byte != LOCK_OPEN) begin
				bad = 1'b1;
			end else if (tgt_lock_page) begin
				bad = any_locked && (is_debug || !fw_locked);
			end else if (tgt_locked) begin
				// locked pages for locked code only
				bad = is_debug || !fw_locked;
			end
		end
	end

	// **********************************
	// Verdict
	// **********************************
	// A bad request is refused to the debug port and faults firmware, one with no target is refused to either; a firmware fault also sets resp_refused
	always_comb begin
		refuse_nxt = 1'b0;
		fault_nxt  = 1'b0;
		if (tgt_nxt == FSAG_TGT_NONE) begin
			refuse_nxt = 1'b1;
		end else if (bad) begin
			refuse_nxt = is_debug;
			fault_nxt  = !is_debug;
		end
	end

	// Intake freezes while a fault reset is pending, so no later request slips past it
	assign take_req = req_valid && !fault_req_r;

	assign dev_erase_go = take_req && is_debug && req_op == FSAG_OP_DEV_ERASE;

	// **********************************
	// Response register
	// **********************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			resp_valid_r   <= 1'b0;
			resp_target_r  <= FSAG_TGT_NONE;
			resp_op_r      <= FSAG_OP_READ;
			resp_addr_r    <= '0;
			resp_refused_r <= 1'b0;
		end else begin
			// Nothing is taken once a fault reset is under way
			resp_valid_r   <= take_req;
			resp_op_r      <= eff_op;
			resp_addr_r    <= req_addr;
			resp_refused_r <= take_req && (refuse_nxt || fault_nxt);
			if (take_req && !refuse_nxt && !fault_nxt) begin
				resp_target_r <= tgt_nxt;
			end else begin
				resp_target_r <= FSAG_TGT_NONE;
			end
		end
	end

	// **********************************
	// Fault reset
	// **********************************
	// Held until the system answers with a reset, so a slow reset block cannot miss it
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fault_req_r <= 1'b0;
		end else if (req_valid && fault_nxt) begin
			fault_req_r <= 1'b1;
		end
	end

	// **********************************
	// Reset cause
	// **********************************
	always_ff @(posedge core_clk) begin
		if (power_on_rst) begin
			rst_prev_r <= 1'b0;
		end else begin
			rst_prev_r <= rst;
		end
	end

	// Flag survives the reset it caused; any other reset clears it
	always_ff @(posedge core_clk) begin
		if (power_on_rst) begin
			flag_r <= 1'b0;
		end else if (rst && !rst_prev_r) begin
			flag_r <= fault_req_r;
		end
	end

	// **********************************
	// Outputs
	// **********************************
	assign resp_valid             = resp_valid_r;
	assign resp_target            = resp_target_r;
	assign resp_op                = resp_op_r;
	assign resp_addr              = resp_addr_r;
	assign resp_refused           = resp_refused_r;
	assign flash_fault_reset      = fault_req_r;
	assign flash_fault_reset_flag = flag_r;
endmodule : fsag_guard

// *** fsag_monitor.sv ***
`timescale 1ns/100ps
module fsag_monitor
	import fsag_pkg::*;
(
	input wire logic              core_clk,
	input wire logic              rst,
	input wire logic              power_on_rst,
	input wire logic              store_write_enable,
	input wire logic              req_valid,
	input wire fsag_src_type      req_src,
	input wire fsag_op_type       req_op,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic              resp_valid,
	input wire fsag_tgt_type      resp_target,
	input wire logic [ADDR_W-1:0] resp_addr,
	input wire logic              resp_refused,
	input wire logic              flash_fault_reset,
	input wire logic              flash_fault_reset_flag
);
	// ****************
	// Port relations
	// ****************
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic tk;
	logic fw_onchip_external_data_ram;
	logic rsv_flash;
	assign tk = req_valid && !flash_fault_reset;
	// Firmware moves that go to the on-chip RAM never touch the reserved flash
	assign fw_onchip_external_data_ram = req_op == FSAG_OP_XDATA_READ || (req_op == FSAG_OP_WRITE && !store_write_enable);
	// Device erase sweeps the whole array, so its address carries no meaning
	assign rsv_flash = tk && req_addr >= RESERVED_BASE && req_op != FSAG_OP_DEV_ERASE
		&& !(req_src == FSAG_SRC_FW && fw_onchip_external_data_ram);
	AST_RESP_NEXT: assert property (tk |=> resp_valid && resp_addr == $past(req_addr))
		else $error("missing or wrong response");
	AST_NO_SPUR: assert property (!tk |=> !resp_valid)
		else $error("response without request");
	AST_XDATA: assert property (tk && req_src == FSAG_SRC_FW && req_op == FSAG_OP_XDATA_READ
		|=> resp_target == FSAG_TGT_ONCHIP_EXTERNAL_DATA_RAM)
		else $error("external read not steered to ram");
	AST_NO_WE: assert property (tk && req_src == FSAG_SRC_FW && req_op != FSAG_OP_READ
		&& !store_write_enable |=> resp_target != FSAG_TGT_FLASH)
		else $error("flash modified without write enable");
	AST_DBG_SAFE: assert property (tk && req_src == FSAG_SRC_DEBUG |=> !flash_fault_reset)
		else $error("debug request reset the device");
	AST_RSV: assert property (rsv_flash |=> resp_refused)
		else $error("reserved area reachable");
	AST_REF_NONE: assert property (resp_refused |-> resp_target == FSAG_TGT_NONE && resp_valid)
		else $error("refused access has a target");
	AST_FAULT_HOLD: assert property ($rose(flash_fault_reset) |-> resp_refused ##1 flash_fault_reset [*3])
		else $error("fault reset dropped early");
	AST_FLAG: assert property (disable iff (power_on_rst)
		$rose(rst) && flash_fault_reset |=> flash_fault_reset_flag)
		else $error("fault flag not set by fault reset");
endmodule : fsag_monitor

bind fsag_guard fsag_monitor fsag_monitor_inst (.*);

// *** fsag_partner.sv ***
`timescale 1ns/100ps
module fsag_partner
	import fsag_pkg::*;
(
	input  wire logic        core_clk,
	output logic              req_valid,
	output fsag_src_type      req_src,
	output fsag_op_type       req_op,
	output logic [ADDR_W-1:0] req_addr,
	output logic [ADDR_W-1:0] exec_addr
);
	initial begin
		req_valid = 1'b0;
		req_src = FSAG_SRC_FW;
		req_op = FSAG_OP_READ;
		req_addr = '0;
		exec_addr = '0;
	end
	// One-cycle strobe; the released address is scrambled so stale values never match
	task automatic issue(input fsag_src_type s, input fsag_op_type o, input logic [ADDR_W-1:0] a, x);
		@(negedge core_clk);
		req_valid = 1'b1;
		req_src = s;
		req_op = o;
		req_addr = a;
		exec_addr = x;
		@(negedge core_clk);
		req_valid = 1'b0;
		req_addr = ~a;
	endtask : issue
endmodule : fsag_partner

// *** fsag_guard_tb_top.sv ***
`timescale 1ns/100ps
module fsag_guard_tb_top;
	import fsag_pkg::*;
	logic core_clk, rst, power_on_rst, store_write_enable, store_erase_enable;
	logic [7:0] flash_lock_byte;
	logic req_valid, resp_valid, resp_refused, flash_fault_reset, flash_fault_reset_flag;
	fsag_src_type req_src;
	fsag_op_type req_op, resp_op;
	fsag_tgt_type resp_target;
	logic [ADDR_W-1:0] req_addr, exec_addr, resp_addr;
	int error_cnt = 0;
	int n_checks = 0;
	fsag_partner fsag_partner_inst (.core_clk(core_clk), .req_valid(req_valid), .req_src(req_src),
		.req_op(req_op), .req_addr(req_addr), .exec_addr(exec_addr));
	fsag_guard fsag_guard_inst (.core_clk(core_clk), .rst(rst), .power_on_rst(power_on_rst),
		.store_write_enable(store_write_enable), .store_erase_enable(store_erase_enable),
		.flash_lock_byte(flash_lock_byte), .exec_addr(exec_addr), .req_valid(req_valid), .req_src(req_src),
		.req_op(req_op), .req_addr(req_addr), .resp_valid(resp_valid), .resp_target(resp_target),
		.resp_op(resp_op), .resp_addr(resp_addr), .resp_refused(resp_refused),
		.flash_fault_reset(flash_fault_reset), .flash_fault_reset_flag(flash_fault_reset_flag));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic chk(input string n, input logic [16:0] e, g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic do_reset(input logic por);
		rst = 1'b1;
		power_on_rst = por;
		repeat (16) @(negedge core_clk);
		rst = 1'b0;
		power_on_rst = 1'b0;
		repeat (2) @(negedge core_clk);
	endtask : do_reset
	// Answer is sampled a half cycle after the taking edge, while it stands
	task automatic op(input fsag_src_type s, input fsag_op_type o, input logic [16:0] a, x,
		input fsag_tgt_type t, input logic r, f);
		fsag_partner_inst.issue(s, o, a, x);
		chk("resp_valid", 17'h1, resp_valid);
		chk("resp_target", t, resp_target);
		chk("resp_refused", r, resp_refused);
		chk("flash_fault_reset", f, flash_fault_reset);
		chk("resp_addr", a, resp_addr);
	endtask : op
	task automatic sc_open;
		store_write_enable = 1'b0;
		chk("fault_flag", 17'h0, flash_fault_reset_flag);
		op(FSAG_SRC_FW, FSAG_OP_READ, 17'h00010, 17'h00000, FSAG_TGT_FLASH, 0, 0);
		op(FSAG_SRC_FW, FSAG_OP_WRITE, 17'h00020, 17'h00000, FSAG_TGT_ONCHIP_EXTERNAL_DATA_RAM, 0, 0);
		op(FSAG_SRC_FW, FSAG_OP_XDATA_READ, 17'h00030, 17'h00000, FSAG_TGT_ONCHIP_EXTERNAL_DATA_RAM, 0, 0);
		store_write_enable = 1'b1;
		store_erase_enable = 1'b1;
		op(FSAG_SRC_FW, FSAG_OP_WRITE, 17'h00400, 17'h00000, FSAG_TGT_FLASH, 0, 0);
		chk("resp_op", FSAG_OP_ERASE, resp_op);
		op(FSAG_SRC_DEBUG, FSAG_OP_ERASE, LOCK_BYTE_ADDR, 17'h00000, FSAG_TGT_FLASH, 0, 0);
	endtask : sc_open
	task automatic sc_locked;
		flash_lock_byte = 8'hfd;
		op(FSAG_SRC_FW, FSAG_OP_READ, 17'h00100, 17'h00800, FSAG_TGT_FLASH, 0, 0);
		do_reset(1'b0);
		op(FSAG_SRC_DEBUG, FSAG_OP_READ, 17'h00100, 17'h00000, FSAG_TGT_NONE, 1, 0);
		op(FSAG_SRC_DEBUG, FSAG_OP_READ, LOCK_BYTE_ADDR, 17'h00000, FSAG_TGT_NONE, 1, 0);
		op(FSAG_SRC_DEBUG, FSAG_OP_ERASE, LOCK_BYTE_ADDR, 17'h00000, FSAG_TGT_NONE, 1, 0);
		op(FSAG_SRC_DEBUG, FSAG_OP_READ, RESERVED_BASE, 17'h00000, FSAG_TGT_NONE, 1, 0);
		op(FSAG_SRC_FW, FSAG_OP_READ, 17'h00300, 17'h00000, FSAG_TGT_FLASH, 0, 0);
		op(FSAG_SRC_FW, FSAG_OP_READ, 17'h00400, 17'h00800, FSAG_TGT_FLASH, 0, 0);
		op(FSAG_SRC_FW, FSAG_OP_READ, LOCK_BYTE_ADDR, LOCK_BYTE_ADDR, FSAG_TGT_FLASH, 0, 0);
		op(FSAG_SRC_FW, FSAG_OP_READ, 17'h003ff, 17'h00800, FSAG_TGT_NONE, 1, 1);
		do_reset(1'b0);
		chk("fault_flag", 17'h1, flash_fault_reset_flag);
		op(FSAG_SRC_FW, FSAG_OP_WRITE, LOCK_BYTE_ADDR, 17'h00000, FSAG_TGT_NONE, 1, 1);
		do_reset(1'b0);
		store_erase_enable = 1'b0;
		op(FSAG_SRC_FW, FSAG_OP_WRITE, LOCK_BYTE_ADDR, 17'h00000, FSAG_TGT_NONE, 1, 1);
		do_reset(1'b0);
		op(FSAG_SRC_FW, FSAG_OP_READ, 17'h1fff0, 17'h00000, FSAG_TGT_NONE, 1, 1);
		do_reset(1'b0);
	endtask : sc_locked
	task automatic sc_erase;
		op(FSAG_SRC_DEBUG, FSAG_OP_DEV_ERASE, 17'h00000, 17'h00000, FSAG_TGT_FLASH, 0, 0);
		flash_lock_byte = 8'hff;
		op(FSAG_SRC_DEBUG, FSAG_OP_READ, 17'h00100, 17'h00000, FSAG_TGT_FLASH, 0, 0);
		do_reset(1'b0);
		chk("fault_flag", 17'h0, flash_fault_reset_flag);
		op(FSAG_SRC_DEBUG, FSAG_OP_READ, LOCK_BYTE_ADDR, 17'h00000, FSAG_TGT_FLASH, 0, 0);
	endtask : sc_erase
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	initial begin
		store_write_enable = 1'b0;
		store_erase_enable = 1'b0;
		flash_lock_byte = 8'hff;
		do_reset(1'b1);
		sc_open();
		sc_locked();
		sc_erase();
		end_sim();
	end
endmodule : fsag_guard_tb_top
